// *** rtl/modem_mgr_pkg.sv ***
// Constants, types and tables for the modem connection manager
package modem_mgr_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned PAUSE_MS = 500;
  localparam int unsigned PAUSE_CYC = PAUSE_MS * (CLK_HZ / 1000);
  localparam int unsigned WAIT_W = 27;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CMD = 4'h8;
  localparam int CTRL_AUTODIAL = 0;
  localparam int CTRL_ANSWER = 1;
  localparam int CTRL_PW_REQ = 2;
  localparam int CTRL_HANGUP = 4;
  localparam int STAT_STATE = 0;
  localparam int STAT_DCD = 3;
  localparam int STAT_DTR = 4;
  localparam int STAT_CMD_FULL = 5;
  localparam int STAT_WAIT = 6;
  localparam int STAT_REJ = 7;
  localparam int STAT_HOST = 8;
  localparam int STAT_PROTO = 9;
  localparam int STAT_NSM = 10;
  localparam int PIN_DCD = 0;
  localparam int PIN_HOST = 1;
  localparam int PIN_PROTO = 2;
  localparam int PIN_NSM = 3;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_BSL = 8'h5c;
  localparam logic [7:0] CH_TILDE = 8'h7e;
  localparam logic [7:0] CH_BANG = 8'h21;
  // Result words: 0 connect, 1 busy, 2 voice, 3 error, 4 no
  localparam logic [4:0][55:0] WORD_TXT = {56'("NO"), 56'("ERROR"),
    56'("VOICE"), 56'("BUSY"), 56'("CONNECT")};
  localparam logic [4:0][3:0] WORD_LEN = {4'h2, 4'h5, 4'h5, 4'h4, 4'h7};
  localparam logic [4:0] WORD_PREFIX = 5'h11;
  localparam logic [4:0] WORD_ALL = 5'h1f;
  localparam logic [4:0] WORD_FAIL = 5'h1e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CALL = 3'b001,
    ST_CONN = 3'b010,
    ST_FAIL = 3'b011,
    ST_AUTH = 3'b100
  } conn_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  function automatic logic [7:0] word_char(input int w, input int i);
    word_char = WORD_TXT[w][8 * (int'(WORD_LEN[w]) - 1 - i) +: 8];
  endfunction : word_char
endpackage : modem_mgr_pkg

// *** rtl/modem_connection_manager.sv ***
// Dial-up link manager: connection states, result parsing, command feed
// Overview of operation
// - Power-up reset enters idle; idle drops all host-bound traffic.
// - Carrier detect loss returns any state to idle.
// - A node-started call enters dialing; uplink traffic still dropped.
// - Completed call, local or incoming, enters connected; traffic passes.
// - Failed attempt enters failed state, behaving like idle.
// - Software reset keeps connection state; power reset clears it.
// - Line starting CONNECT, ended by carriage return, means success.
// - BUSY, VOICE, ERROR or lines starting NO mean failure.
// - Only command bytes are translated; backslash passes next byte.
// - Tilde pauses 500 ms before next byte and is not sent.
// - Exclamation mark is sent as carriage return instead.
// - Carrier detect proves a connection; terminal ready hangs up.
// - Modem features work only with remote host location selected.
// - Host processor mode never dials on its own.
// - Network services mode may dial on its own when enabled.
// - Answered calls may need a password before connecting.
// - Command bytes are refused while connected.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
module modem_connection_manager
  import modem_mgr_pkg::*;
#(
  parameter int unsigned PAUSE_CYCLES = modem_mgr_pkg::PAUSE_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire modem_mgr_pkg::reg_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire logic dcd_pin,
  output logic dtr_pin,
  input wire logic host_location_select,
  input wire logic link_protocol_select,
  input wire logic network_services_mode,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic node_call_req,
  input wire logic auto_dial_req,
  input wire logic password_ok,
  input wire logic up_in_valid,
  input wire logic [7:0] up_in_data,
  output logic up_out_valid,
  output logic [7:0] up_out_data,
  output logic up_drop,
  output modem_mgr_pkg::conn_state_t conn_state
);
  import modem_mgr_pkg::*;

  if (PAUSE_CYCLES < 1 || PAUSE_CYCLES >= (64'd1 << WAIT_W))
  begin : g_bad_pause
    $error("PAUSE_CYCLES out of range");
  end

  typedef struct packed {
    conn_state_t st;
    logic [2:0][3:0] pin_s;
    logic [3:0] pin_f;
    logic dcd_prev;
    logic dtr;
    logic hanging;
    logic [2:0] ctrl;
    logic rejected;
    logic conn_seen;
    logic cmd_full;
    logic [7:0] cmd_char;
    logic esc;
    logic waiting;
    logic [WAIT_W-1:0] wait_cnt;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [3:0] pos;
    logic [4:0] cand;
    logic [31:0] rdata;
    logic up_valid;
    logic [7:0] up_data;
    logic up_drop;
  } state_t;

  state_t s;
  state_t next_s;
  logic [4:0] hit;
  logic line_end;
  logic connect_hit;
  logic fail_hit;
  logic dcd;
  logic dcd_fall;
  logic modem_on;
  logic take;
  logic got_connect;

  assign dcd = s.pin_f[PIN_DCD];
  assign dcd_fall = s.dcd_prev && !dcd;
  assign modem_on = s.pin_f[PIN_HOST];
  assign take = s.cmd_full && !s.waiting && (!s.tx_valid || tx_ready);
  assign line_end = rx_valid && rx_data == CH_CR;

  // Word hit needs the whole word seen; exact words die on extra text
  always_comb
  begin
    for (int w = 0; w < 5; w++)
    begin
      hit[w] = s.cand[w] && s.pos >= WORD_LEN[w];
    end
  end

  assign connect_hit = line_end && hit[0];
  assign fail_hit = line_end && |(hit & WORD_FAIL);
  assign got_connect = connect_hit || s.conn_seen;

  always_comb
  begin
    next_s = s;
    next_s.pin_s = {s.pin_s[1:0], network_services_mode,
      link_protocol_select, host_location_select, dcd_pin};
    for (int i = 0; i < 4; i++)
    begin
      if (s.pin_s[1][i] == s.pin_s[2][i])
      begin
        next_s.pin_f[i] = s.pin_s[2][i];
      end
    end
    next_s.dcd_prev = dcd;
    next_s.rdata = '0;
    next_s.up_valid = 1'b0;
    next_s.up_drop = 1'b0;
    if (s.tx_valid && tx_ready)
    begin
      next_s.tx_valid = 1'b0;
    end
    // Register reads
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        REG_CTRL: next_s.rdata[2:0] = s.ctrl;
        REG_STATUS:
        begin
          next_s.rdata[STAT_STATE +: 3] = s.st;
          next_s.rdata[STAT_DCD] = dcd;
          next_s.rdata[STAT_DTR] = s.dtr;
          next_s.rdata[STAT_CMD_FULL] = s.cmd_full;
          next_s.rdata[STAT_WAIT] = s.waiting;
          next_s.rdata[STAT_REJ] = s.rejected;
          next_s.rdata[STAT_HOST] = s.pin_f[PIN_HOST];
          next_s.rdata[STAT_PROTO] = s.pin_f[PIN_PROTO];
          next_s.rdata[STAT_NSM] = s.pin_f[PIN_NSM];
        end
        REG_CMD: next_s.rdata[0] = s.cmd_full;
        default: next_s.rdata = '0;
      endcase
    end
    // Release comes first so that a fresh hang-up write wins
    if (s.hanging && !dcd)
    begin
      next_s.dtr = 1'b1;
      next_s.hanging = 1'b0;
    end
    // Register writes
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        REG_CTRL:
        begin
          next_s.ctrl = bus_req.wdata[2:0];
          if (bus_req.wdata[CTRL_HANGUP])
          begin
            next_s.dtr = 1'b0;
            next_s.hanging = 1'b1;
          end
        end
        REG_STATUS:
        begin
          if (bus_req.wdata[STAT_REJ])
          begin
            next_s.rejected = 1'b0;
          end
        end
        REG_CMD:
        begin
          if (s.st == ST_CONN || s.cmd_full)
          begin
            next_s.rejected = 1'b1;
          end
          else
          begin
            next_s.cmd_full = 1'b1;
            next_s.cmd_char = bus_req.wdata[7:0];
          end
        end
        default: next_s.ctrl = s.ctrl;
      endcase
    end
    // Command byte feed with translation
    if (s.waiting)
    begin
      if (s.wait_cnt == '0)
      begin
        next_s.waiting = 1'b0;
      end
      else
      begin
        next_s.wait_cnt = s.wait_cnt - 1'b1;
      end
    end
    else if (take)
    begin
      next_s.cmd_full = 1'b0;
      if (s.esc)
      begin
        next_s.esc = 1'b0;
        next_s.tx_valid = 1'b1;
        next_s.tx_data = s.cmd_char;
      end
      else
      begin
        case (s.cmd_char)
          CH_BSL: next_s.esc = 1'b1;
          CH_TILDE:
          begin
            next_s.waiting = 1'b1;
            next_s.wait_cnt = WAIT_W'(PAUSE_CYCLES - 1);
          end
          CH_BANG:
          begin
            next_s.tx_valid = 1'b1;
            next_s.tx_data = CH_CR;
          end
          default:
          begin
            next_s.tx_valid = 1'b1;
            next_s.tx_data = s.cmd_char;
          end
        endcase
      end
    end
    // Result line matcher; leading line feed of a new line is skipped
    if (line_end)
    begin
      next_s.pos = '0;
      next_s.cand = WORD_ALL;
    end
    else if (rx_valid && !(rx_data == CH_LF && s.pos == '0))
    begin
      for (int w = 0; w < 5; w++)
      begin
        if (s.pos < WORD_LEN[w])
        begin
          if (rx_data != word_char(w, int'(s.pos)))
          begin
            next_s.cand[w] = 1'b0;
          end
        end
        else if (!WORD_PREFIX[w])
        begin
          next_s.cand[w] = 1'b0;
        end
      end
      if (s.pos != 4'hf)
      begin
        next_s.pos = s.pos + 4'h1;
      end
    end
    // Connection state
    if (!modem_on)
    begin
      next_s.st = ST_IDLE;
    end
    else if (dcd_fall)
    begin
      next_s.st = ST_IDLE;
    end
    else
    begin
      case (s.st)
        ST_IDLE, ST_FAIL:
        begin
          if (node_call_req || (auto_dial_req && s.pin_f[PIN_NSM] &&
              s.ctrl[CTRL_AUTODIAL]))
          begin
            next_s.st = ST_CALL;
          end
          else if (s.ctrl[CTRL_ANSWER] && got_connect && dcd)
          begin
            next_s.st = s.ctrl[CTRL_PW_REQ] ? ST_AUTH : ST_CONN;
          end
        end
        ST_CALL:
        begin
          if (fail_hit)
          begin
            next_s.st = ST_FAIL;
          end
          else if (got_connect && dcd)
          begin
            next_s.st = ST_CONN;
          end
        end
        ST_AUTH:
        begin
          if (password_ok)
          begin
            next_s.st = ST_CONN;
          end
        end
        ST_CONN: next_s.st = ST_CONN;
        default: next_s.st = ST_IDLE;
      endcase
    end
    next_s.conn_seen = (next_s.st == s.st) && got_connect;
    // Uplink gate
    if (up_in_valid)
    begin
      if (!modem_on || s.st == ST_CONN)
      begin
        next_s.up_valid = 1'b1;
        next_s.up_data = up_in_data;
      end
      else
      begin
        next_s.up_drop = 1'b1;
      end
    end
    // Software reset leaves the connection and terminal ready alone
    if (soft_rst)
    begin
      next_s.cmd_full = 1'b0;
      next_s.esc = 1'b0;
      next_s.waiting = 1'b0;
      next_s.tx_valid = 1'b0;
      next_s.pos = '0;
      next_s.cand = WORD_ALL;
      next_s.conn_seen = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.dtr <= 1'b1;
      s.cand <= WORD_ALL;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign bus_rdata = s.rdata;
  assign dtr_pin = s.dtr;
  assign tx_valid = s.tx_valid;
  assign tx_data = s.tx_data;
  assign up_out_valid = s.up_valid;
  assign up_out_data = s.up_data;
  assign up_drop = s.up_drop;
  assign conn_state = s.st;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_take_plain;
    take && !s.esc && !soft_rst;
  endsequence
  sequence s_tx_cr;
    tx_valid && tx_data == CH_CR;
  endsequence

  property p_power_idle;
    $rose(rst_n) |-> conn_state == ST_IDLE && dtr_pin;
  endproperty
  a_power_idle: assert property (p_power_idle) else $error("not idle");
  property p_drop;
    modem_on && up_in_valid && s.st != ST_CONN |=> up_drop && !up_out_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("uplink leak");
  property p_dcd_loss;
    modem_on && dcd_fall |=> conn_state == ST_IDLE;
  endproperty
  a_dcd_loss: assert property (p_dcd_loss) else $error("dcd ignored");
  property p_call;
    modem_on && !dcd_fall && s.st == ST_IDLE && node_call_req
      |=> conn_state == ST_CALL;
  endproperty
  a_call: assert property (p_call) else $error("call not started");
  property p_fail;
    modem_on && !dcd_fall && s.st == ST_CALL && fail_hit
      |=> conn_state == ST_FAIL;
  endproperty
  a_fail: assert property (p_fail) else $error("fail missed");
  property p_connect;
    modem_on && !dcd_fall && s.st == ST_CALL && !fail_hit && connect_hit
      && dcd |=> conn_state == ST_CONN;
  endproperty
  a_connect: assert property (p_connect) else $error("no connect");
  property p_tilde;
    s_take_plain and s.cmd_char == CH_TILDE |=> s.waiting && !tx_valid;
  endproperty
  a_tilde: assert property (p_tilde) else $error("tilde sent");
  property p_bang;
    s_take_plain and s.cmd_char == CH_BANG |=> s_tx_cr;
  endproperty
  a_bang: assert property (p_bang) else $error("bang not cr");
  property p_escape;
    take && s.esc && !soft_rst |=> tx_valid && tx_data == $past(s.cmd_char);
  endproperty
  a_escape: assert property (p_escape) else $error("escape lost");
  property p_reject;
    bus_req.wr && bus_req.addr == REG_CMD && s.st == ST_CONN
      |=> s.rejected ##1 !$rose(s.cmd_full);
  endproperty
  a_reject: assert property (p_reject) else $error("cmd taken");
  property p_hangup;
    bus_req.wr && bus_req.addr == REG_CTRL && bus_req.wdata[CTRL_HANGUP]
      |=> !dtr_pin;
  endproperty
  a_hangup: assert property (p_hangup) else $error("dtr held");
endmodule : modem_connection_manager

// *** verif/modem_model.sv ***
// Behavioural modem: carrier, result lines and a command byte sink
module modem_model
(
  input wire logic clk_sys,
  input wire logic dtr_pin,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic dcd_pin,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic carrier = 1'b0;
  logic [7:0] got[$];
  time at[$];
  initial
  begin
    tx_ready = 1'b0;
    dcd_pin = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // Random stalls on the byte sink
  always @(posedge clk_sys)
  begin
    tx_ready <= 1'($urandom);
    if (tx_valid && tx_ready)
    begin
      got.push_back(tx_data);
      at.push_back($time);
    end
    if (!dtr_pin)
      carrier <= 1'b0;
    dcd_pin <= carrier && dtr_pin;
  end
  task automatic link(input logic up);
    @(posedge clk_sys);
    carrier <= up;
  endtask : link
  // Idle data shows the inverse of the last byte
  task automatic send(input logic [7:0] b);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : send
  // Result lines of any text, digits too; line end optional
  task automatic say(input string s, input bit cr);
    foreach (s[i])
      send(s[i]);
    if (cr)
      send(8'h0d);
  endtask : say
endmodule : modem_model

// *** verif/modem_connection_manager_tb.sv ***
// Self-checking bench for the modem connection manager
module modem_connection_manager_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import modem_mgr_pkg::*;
  localparam int unsigned PAUSE = 40;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t bus_req = '0;
  logic [31:0] bus_rdata, v;
  logic dcd_pin, dtr_pin, tx_valid, tx_ready, rx_valid, up_out_valid, up_drop;
  logic [7:0] tx_data, rx_data, up_out_data;
  logic host = 1'b1, proto = 1'b1, nsm = 1'b0, up_in_valid = 1'b0;
  logic [7:0] up_in_data = 8'h00;
  logic [3:0] ev = '0;
  conn_state_t conn_state;
  int fail_count = 0, comparisons = 0, cycles = 0;
  time t0;
  string fails[4] = '{"BUSY", "VOICE", "ERROR", "NO CARRIER"};

  always #2 clk_sys = ~clk_sys;

  modem_connection_manager #(.PAUSE_CYCLES(PAUSE)) DUT (.clk_sys(clk_sys),
    .rst_n(rst_n), .soft_rst(ev[3]), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .dcd_pin(dcd_pin), .dtr_pin(dtr_pin), .host_location_select(host),
    .link_protocol_select(proto), .network_services_mode(nsm),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .node_call_req(ev[0]),
    .auto_dial_req(ev[1]), .password_ok(ev[2]), .up_in_valid(up_in_valid),
    .up_in_data(up_in_data), .up_out_valid(up_out_valid),
    .up_out_data(up_out_data), .up_drop(up_drop), .conn_state(conn_state));

  modem_model modem (.clk_sys(clk_sys), .dtr_pin(dtr_pin),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .dcd_pin(dcd_pin), .rx_valid(rx_valid), .rx_data(rx_data));

  task automatic results;
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic st(input conn_state_t e);
    @(negedge clk_sys);
    chk(32'(conn_state), 32'(e));
  endtask : st

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk_sys);
    bus_req <= '0;
    // Read data stand for one cycle only; look mid-cycle
    @(negedge clk_sys);
    d = bus_rdata;
  endtask : rd

  // Event pulses: 0 call, 1 self-dial, 2 password, 3 soft reset
  task automatic pulse(input int k);
    @(posedge clk_sys);
    ev[k] <= 1'b1;
    @(posedge clk_sys);
    ev <= '0;
  endtask : pulse

  task automatic up(input logic pass, input logic [7:0] d);
    @(posedge clk_sys);
    up_in_valid <= 1'b1;
    up_in_data <= d;
    @(posedge clk_sys);
    up_in_valid <= 1'b0;
    @(negedge clk_sys);
    chk({22'h0, up_out_valid, up_drop, pass ? up_out_data : d},
      {22'h0, pass, !pass, d});
  endtask : up

  // Write one command byte, then poll until it is taken
  task automatic cmd(input logic [7:0] b);
    wr(REG_CMD, {24'h0, b});
    v = 32'h1;
    for (int i = 0; i < 60 && v[0]; i++)
      rd(REG_CMD, v);
  endtask : cmd

  function automatic logic [31:0] stat(input conn_state_t s,
    input logic dcd, input logic rej);
    return {21'h0, nsm, proto, host, rej, 3'b001, dcd, 3'(s)};
  endfunction : stat

  task automatic dial(input string s, input conn_state_t e);
    pulse(0);
    tick(2);
    st(ST_CALL);
    up(1'b0, 8'h5a);
    modem.say(s, 1'b1);
    tick(8);
    st(e);
  endtask : dial

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
  end

  initial
  begin
    v = $urandom(6329);
    tick(3);
    rst_n <= 1'b1;
    tick(6);
    st(ST_IDLE);
    up(1'b0, 8'h33);
    rd(REG_STATUS, v);
    chk(v, stat(ST_IDLE, 1'b0, 1'b0));
    rd(4'hc, v);
    chk(v, 32'h0);
    cmd(8'h41);
    t0 = $time;
    cmd(CH_TILDE);
    cmd(CH_BSL);
    cmd(CH_BANG);
    cmd(CH_BANG);
    cmd(8'h42);
    for (int i = 0; i < 50 && modem.got.size() < 4; i++)
      tick(1);
    chk(32'(modem.got.size()), 32'h4);
    chk({modem.got[0], modem.got[1], modem.got[2], modem.got[3]},
      32'h41210d42);
    chk(32'(modem.at[1] - t0 >= PAUSE * 4), 32'h1);
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, v);
    chk(v, 32'h1);
    pulse(1);
    tick(2);
    st(ST_IDLE);
    nsm <= 1'b1;
    tick(6);
    pulse(1);
    tick(2);
    st(ST_CALL);
    modem.say("NO DIALTONE", 1'b1);
    tick(4);
    st(ST_FAIL);
    nsm <= 1'b0;
    wr(REG_CTRL, 32'h0);
    modem.link(1'b1);
    pulse(0);
    tick(2);
    st(ST_CALL);
    modem.say("XCONNECT 1", 1'b1);
    modem.say("CONNECT", 1'b0);
    tick(8);
    st(ST_CALL);
    pulse(3);
    tick(2);
    st(ST_CALL);
    modem.say("BUSY", 1'b1);
    tick(4);
    st(ST_FAIL);
    modem.link(1'b0);
    tick(8);
    st(ST_IDLE);
    foreach (fails[i])
    begin
      dial(fails[i], ST_FAIL);
      up(1'b0, 8'(i));
    end
    modem.link(1'b1);
    dial($sformatf("CONNECT %0d", $urandom_range(300, 57600)), ST_CONN);
    up(1'b1, 8'($urandom));
    up(1'b1, CH_BANG);
    wr(REG_CMD, 32'h41);
    rd(REG_STATUS, v);
    chk(v, stat(ST_CONN, 1'b1, 1'b1));
    chk(32'(modem.got.size()), 32'h4);
    pulse(3);
    tick(2);
    st(ST_CONN);
    wr(REG_STATUS, 32'h80);
    wr(REG_CTRL, 32'h10);
    tick(2);
    chk(32'(dtr_pin), 32'h0);
    tick(12);
    st(ST_IDLE);
    chk(32'(dtr_pin), 32'h1);
    wr(REG_CTRL, 32'h6);
    modem.link(1'b1);
    modem.say("CONNECT", 1'b1);
    tick(6);
    st(ST_AUTH);
    pulse(2);
    tick(2);
    st(ST_CONN);
    rst_n <= 1'b0;
    tick(3);
    rst_n <= 1'b1;
    tick(1);
    st(ST_IDLE);
    host <= 1'b0;
    tick(6);
    up(1'b1, 8'h7e);
    results();
  end
endmodule : modem_connection_manager_tb
